// [tb/bus_options_reg_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module bus_options_props (
    input wire logic        MCLK_I,
    input wire logic        RST_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        BLK_WR_VALID_I,
    input wire logic [15:0] BLK_WR_LEN_I,
    input wire logic        ACK_TYPE_ERR_O,
    input wire logic [31:0] BUS_OPTIONS_O,
    input wire logic        PM_CAPABLE_O
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    sequence rd_taken;
        HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
    endsequence
    a_speed_fixed: assert property (!$past(RST_I) |-> BUS_OPTIONS_O[2:0] == 3'h3)
        else $error("link speed code wrong");
    a_reserved_zero: assert property (!$past(RST_I) |-> (BUS_OPTIONS_O & 32'h07000f38) == 32'h0)
        else $error("reserved bits not zero");
    a_pm_follows: assert property (PM_CAPABLE_O == BUS_OPTIONS_O[27])
        else $error("power flag differs from quadlet");
    a_code_floor: assert property (!$past(RST_I) |-> BUS_OPTIONS_O[15:12] >= 4'h8)
        else $error("size code below 512 bytes");
    a_unmapped_zero: assert property (rd_taken ##0 HADDR_I[11:0] != 12'h020 |=> HRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_read_fixed: assert property (rd_taken ##0 HADDR_I[11:0] == 12'h020 |=> (HRDATA_O & 32'h07000f3f) == 32'h3)
        else $error("read fixed bits wrong");
    a_err_cause: assert property (ACK_TYPE_ERR_O |-> $past(BLK_WR_VALID_I) && $past(BLK_WR_LEN_I) > 16'd512)
        else $error("type error without oversize request");
    a_small_ok: assert property (BLK_WR_VALID_I && BLK_WR_LEN_I <= 16'd512 |=> !ACK_TYPE_ERR_O)
        else $error("type error on legal length");
    a_hard_default: assert property ($fell(RST_I) |=> BUS_OPTIONS_O[15:12] == 4'hb)
        else $error("size code not 4096 bytes after reset");
endmodule
bind bus_options_reg bus_options_props bus_options_props_i (.MCLK_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I,
    .HWRITE_I, .HREADY_I, .HRDATA_O, .BLK_WR_VALID_I, .BLK_WR_LEN_I, .ACK_TYPE_ERR_O, .BUS_OPTIONS_O, .PM_CAPABLE_O);
`default_nettype wire

// [tb/serial_bus_options_register_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_bus_options_register_tb;
    logic        clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, blk_v = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  ev = 3'h0;
    logic        link_on = 1'b1;
    logic [15:0] blk_len = 16'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire         hready, ack, pm, resp;
    wire  [31:0] hrdata, opts;
    int          mismatches = 0, tests_run = 0;
    bus_options_reg bus_options_reg_i (.MCLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(resp), .SOFT_RESET_I(ev[2]), .LINK_ON_SWITCH_I(link_on),
        .ROM_CHANGED_I(ev[0]), .BUS_RESET_I(ev[1]), .BLK_WR_VALID_I(blk_v), .BLK_WR_LEN_I(blk_len), .ACK_TYPE_ERR_O(ack),
        .BUS_OPTIONS_O(opts), .PM_CAPABLE_O(pm));
    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Called just after a rising edge; read data taken at the edge closing the data phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, resp}, 32'h0);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic look(input logic [31:0] exp);
        @(negedge clk);
        chk(opts, exp);
        chk({31'h0, pm}, {31'h0, exp[27]});
        @(posedge clk);
    endtask
    task automatic pulse(input logic [2:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 3'h0;
        @(posedge clk);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        rdchk(12'h020, 32'h0000b003);
        look(32'h0000b003);
        $display("reset values done");
    endtask
    task automatic t_fields;
        xfer(1'b1, 12'h020, 32'hffffffff);
        rdchk(12'h020, 32'hf8fff0c3);
        look(32'hf8fff0c3);
        xfer(1'b1, 12'h020, 32'h08007000);
        rdchk(12'h020, 32'h0800f003);
        xfer(1'b1, 12'h024, 32'hffffffff);
        rdchk(12'h024, 32'h0);
        rdchk(12'h020, 32'h0800f003);
        $display("field access done");
    endtask
    task automatic t_len;
        for (int c = 8; c <= 14; c += 3) begin
            xfer(1'b1, 12'h020, {16'h0, c[3:0], 12'h0});
            for (int k = 0; k < 2; k++) begin
                blk_v <= 1'b1;
                blk_len <= (16'd1 << (c + 1)) + k[15:0];
                @(posedge clk);
                blk_v <= 1'b0;
                @(negedge clk);
                chk({31'h0, ack}, {31'h0, k[0]});
                @(posedge clk);
            end
        end
        // Largest code: no 16-bit length may exceed 64 KiB
        xfer(1'b1, 12'h020, 32'h0000f000);
        blk_v <= 1'b1;
        blk_len <= 16'hffff;
        @(posedge clk);
        blk_v <= 1'b0;
        @(negedge clk);
        chk({31'h0, ack}, 32'h0);
        @(posedge clk);
        $display("length limit done");
    endtask
    task automatic t_gen;
        for (int i = 1; i <= 4; i++) begin
            pulse(3'h1);
            pulse(3'h2);
            xfer(1'b0, 12'h020, 32'h0);
            chk({30'h0, rd[7:6]}, 32'(i % 4));
        end
        pulse(3'h2);
        rdchk(12'h020, 32'h0000f003);
        // Change beside a bus reset counts now and stays pending
        pulse(3'h3);
        pulse(3'h2);
        rdchk(12'h020, 32'h0000f083);
        $display("generation done");
    endtask
    task automatic t_resets;
        xfer(1'b1, 12'h020, 32'hf8ff9000);
        pulse(3'h4);
        rdchk(12'h020, 32'h00009003);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(12'h020, 32'h0000b003);
        $display("resets done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_fields;
        t_len;
        t_gen;
        t_resets;
        conclude;
    end
    // Whole run is about a hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        conclude;
    end
endmodule
`default_nettype wire

// [verilog/blk_len_check.v]
`timescale 1ns/10ps
`default_nettype none
`include "bus_options_consts.vh"

module blk_len_check (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  rec_code_i,
    input  wire        req_valid_i,
    input  wire [15:0] req_len_i,
    output wire        type_err_o
);

    // ****************************************
    // Byte limit, two to the code plus one
    // ****************************************
    function [16:0] rec_bytes;
        input [3:0] code;
        begin
            // Five-bit shift count, so code fh reaches bit 16
            rec_bytes = 17'h00001 << ({1'b0, code} + 5'h01);
        end
    endfunction

    reg         type_err_ff;
    wire        nxt_type_err;

    // Seventeen bits, since code fh gives 64 KiB
    assign nxt_type_err = req_valid_i & ({1'b0, req_len_i} > rec_bytes(rec_code_i));

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            type_err_ff <= 1'b0;
        end else begin
            type_err_ff <= nxt_type_err;
        end
    end

    assign type_err_o = type_err_ff;

endmodule
`default_nettype wire

// [verilog/bus_options_consts.vh]
`ifndef BUS_OPTIONS_CONSTS_VH
`define BUS_OPTIONS_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define BOPT_OFFSET        12'h020
`define BOPT_ADDR_MSB      11

// ****************************************
// Field layout
// ****************************************
`define BOPT_CAP_MSB       31
`define BOPT_CAP_LSB       27
`define BOPT_PMC_BIT       27
`define BOPT_ACC_MSB       23
`define BOPT_ACC_LSB       16
`define BOPT_REC_MSB       15
`define BOPT_REC_LSB       12
`define BOPT_GEN_MSB       7
`define BOPT_GEN_LSB       6
`define BOPT_SPD_MSB       2
`define BOPT_SPD_LSB       0

// ****************************************
// Reset and fixed values
// ****************************************
`define BOPT_CAP_RST       5'h00
`define BOPT_ACC_RST       8'h00
`define BOPT_REC_RST       4'hb
`define BOPT_GEN_RST       2'h0
`define BOPT_LINK_SPD      3'h3
`define BOPT_REC_MIN       4'h8
`define BOPT_WORD_RST      32'h0000_b003

// ****************************************
// Bus encodings
// ****************************************
`define AHB_TRANS_NONSEQ_BIT 1
`define AHB_RESP_OKAY      1'b0

`endif

// [verilog/bus_options_reg.v]
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "bus_options_consts.vh"

// Overview of operation
// - Bits 31-27 capability flags, read-write, reset zero
// - Bit 27 set publishes power-management capable
// - Bits 23-16 clock accuracy, read-write, reset zero
// - Bits 15-12 size code, limit at least 512
// - Hard reset loads Bh; soft reset keeps it
// - Oversize block write may get type-error acknowledge
// - Generation counter bumps at a bus reset when ROM changed since the last bus reset
// - Reserved bit groups always read zero
// - Bits 2-0 always read link rate 011b
// - Register sits at offset 20h, ninth quadlet
module bus_options_reg (
    input  wire        MCLK_I,
    input  wire        RST_I,
    input  wire        HSEL_I,
    input  wire [31:0] HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    input  wire        HREADY_I,
    output wire [31:0] HRDATA_O,
    output wire        HREADYOUT_O,
    output wire        HRESP_O,
    input  wire        SOFT_RESET_I,
    input  wire        LINK_ON_SWITCH_I,
    input  wire        ROM_CHANGED_I,
    input  wire        BUS_RESET_I,
    input  wire        BLK_WR_VALID_I,
    input  wire [15:0] BLK_WR_LEN_I,
    output wire        ACK_TYPE_ERR_O,
    output wire [31:0] BUS_OPTIONS_O,
    output wire        PM_CAPABLE_O
);

    // ****************************************
    // Word assembly
    // ****************************************
    function [31:0] pack_word;
        input [4:0] cap;
        input [7:0] acc;
        input [3:0] rec;
        input [1:0] gen;
        begin
            // Reserved groups 26-24, 11-8, 5-3 are hard zero
            pack_word = {cap, 3'h0, acc, rec, 4'h0, gen, 3'h0, `BOPT_LINK_SPD};
        end
    endfunction

    // Codes under 8 give fewer than 512 bytes
    function rec_ok;
        input [3:0] code;
        begin
            rec_ok = (code >= `BOPT_REC_MIN);
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg  [4:0]  cap_ff;
    reg  [7:0]  acc_ff;
    reg  [3:0]  rec_ff;
    reg  [1:0]  gen_ff;
    reg         rom_dirty_ff;
    reg         wr_pend_ff;
    reg  [31:0] rdata_ff;
    reg  [31:0] pub_ff;

    reg  [4:0]  nxt_cap;
    reg  [7:0]  nxt_acc;
    reg  [3:0]  nxt_rec;
    reg  [1:0]  nxt_gen;
    reg         nxt_rom_dirty;
    reg  [31:0] nxt_rdata;

    wire        addr_phase;
    wire        hit;
    wire        wr_commit;
    wire [3:0]  wr_rec;
    wire [4:0]  wr_cap;
    wire [7:0]  wr_acc;
    wire [1:0]  wr_gen;
    wire        rec_take;
    wire        rom_event;
    wire        gen_bump;
    wire        rd_hit;
    wire        wr_hit;
    wire [31:0] nxt_word;

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    assign addr_phase  = HSEL_I & HTRANS_I[`AHB_TRANS_NONSEQ_BIT] & HREADY_I;
    assign hit         = (HADDR_I[`BOPT_ADDR_MSB:0] == `BOPT_OFFSET);
    assign wr_commit   = wr_pend_ff & HREADY_I;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = `AHB_RESP_OKAY;
    assign HRDATA_O    = rdata_ff;

    assign wr_cap    = HWDATA_I[`BOPT_CAP_MSB:`BOPT_CAP_LSB];
    assign wr_acc    = HWDATA_I[`BOPT_ACC_MSB:`BOPT_ACC_LSB];
    assign wr_rec    = HWDATA_I[`BOPT_REC_MSB:`BOPT_REC_LSB];
    assign wr_gen    = HWDATA_I[`BOPT_GEN_MSB:`BOPT_GEN_LSB];
    assign rec_take  = wr_commit & rec_ok(wr_rec);
    assign rom_event = rom_dirty_ff | ROM_CHANGED_I;
    assign gen_bump  = BUS_RESET_I & rom_event;
    assign rd_hit    = addr_phase & ~HWRITE_I & hit;
    assign wr_hit    = addr_phase & HWRITE_I & hit;
    assign nxt_word  = pack_word(nxt_cap, nxt_acc, nxt_rec, nxt_gen);

    // ****************************************
    // Capability flags
    // ****************************************
    // Soft reset first, so a write in the same cycle wins
    always @* begin
        nxt_cap = cap_ff;
        if (SOFT_RESET_I) begin
            nxt_cap = `BOPT_CAP_RST;
        end
        if (wr_commit) begin
            nxt_cap = wr_cap;
        end
    end

    // ****************************************
    // Cycle master clock accuracy
    // ****************************************
    always @* begin
        nxt_acc = acc_ff;
        if (SOFT_RESET_I) begin
            nxt_acc = `BOPT_ACC_RST;
        end
        if (wr_commit) begin
            nxt_acc = wr_acc;
        end
    end

    // ****************************************
    // Block request size code
    // ****************************************
    // Soft reset is not looked at: the code survives it
    always @* begin
        nxt_rec = rec_ff;
        if (rec_take) begin
            nxt_rec = wr_rec;
        end
    end

    // ****************************************
    // Generation counter
    // ****************************************
    // Write and bump in one cycle: the bump lands on the written value
    always @* begin
        nxt_gen = gen_ff;
        if (wr_commit) begin
            nxt_gen = wr_gen;
        end
        if (gen_bump) begin
            nxt_gen = nxt_gen + 2'h1;
        end
    end

    // ****************************************
    // Pending ROM change
    // ****************************************
    // Set wins over clear, so a change beside a bus reset stays pending
    always @* begin
        nxt_rom_dirty = rom_event;
        if (BUS_RESET_I) begin
            nxt_rom_dirty = ROM_CHANGED_I;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Forward the next value so a read right after a write sees it
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (rd_hit) begin
            nxt_rdata = nxt_word;
        end
    end

    // ****************************************
    // Capability flag register
    // ****************************************
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            cap_ff <= `BOPT_CAP_RST;
        end else begin
            cap_ff <= nxt_cap;
        end
    end

    // ****************************************
    // Clock accuracy register
    // ****************************************
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            acc_ff <= `BOPT_ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // ****************************************
    // Size code register
    // ****************************************
    // Only the hard reset brings back the 4096-byte code
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rec_ff <= `BOPT_REC_RST;
        end else begin
            rec_ff <= nxt_rec;
        end
    end

    // ****************************************
    // Generation register
    // ****************************************
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            gen_ff <= `BOPT_GEN_RST;
        end else begin
            gen_ff <= nxt_gen;
        end
    end

    // ****************************************
    // ROM change flag register
    // ****************************************
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rom_dirty_ff <= 1'b0;
        end else begin
            rom_dirty_ff <= nxt_rom_dirty;
        end
    end

    // ****************************************
    // Bus side registers
    // ****************************************
    // Pending write is held while another slave stretches the bus
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_pend_ff <= 1'b0;
        end else if (HREADY_I) begin
            wr_pend_ff <= wr_hit;
        end
    end

    // Read data stands for the data phase only
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // Published quadlet register
    // ****************************************
    // Default word during reset keeps the fixed fields valid then too
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            pub_ff <= `BOPT_WORD_RST;
        end else begin
            pub_ff <= nxt_word;
        end
    end

    // ****************************************
    // Published quadlet
    // ****************************************
    assign BUS_OPTIONS_O = pub_ff;
    assign PM_CAPABLE_O  = pub_ff[`BOPT_PMC_BIT];

    // ****************************************
    // Oversize block write check
    // ****************************************
    blk_len_check u_len_check (
        .clk_i       (MCLK_I),
        .rst_i       (RST_I),
        .rec_code_i  (rec_ff),
        .req_valid_i (BLK_WR_VALID_I),
        .req_len_i   (BLK_WR_LEN_I),
        .type_err_o  (ACK_TYPE_ERR_O)
    );

endmodule
`default_nettype wire
